// ===== timer8_regs.svh
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH

// data-space addresses
`define TC_ADDR_FLAGS      8'h37
`define TC_ADDR_MASK       8'h70
`define TC_ADDR_COUNT      8'hB2
`define TC_ADDR_CMP_A      8'hB3
`define TC_ADDR_CMP_B      8'hB4

// short i/o window
`define TC_IO_OFFSET       8'h20
`define TC_IO_LIMIT        8'h40
`define TC_EXT_IO_BASE     8'h60

// bit positions in mask and flag registers
`define TC_BIT_OVF         0
`define TC_BIT_CMP_A       1
`define TC_BIT_CMP_B       2
`define TC_IRQ_BITS        3

// reset values
`define TC_RST_BYTE        8'h00
`define TC_RST_IRQ         3'h0

// count limits
`define TC_COUNT_MAX       8'hFF
`define TC_COUNT_BOTTOM    8'h00
`define TC_COUNT_STEP      8'h01

// clock select codes
`define TC_CS_STOP         3'h0
`define TC_CS_DIV1         3'h1
`define TC_CS_DIV8         3'h2
`define TC_CS_DIV32        3'h3
`define TC_CS_DIV64        3'h4
`define TC_CS_DIV128       3'h5
`define TC_CS_DIV256       3'h6
`define TC_CS_DIV1024      3'h7

// prescaler tap widths, log2 of each division
`define TC_LOG_DIV8        3
`define TC_LOG_DIV32       5
`define TC_LOG_DIV64       6
`define TC_LOG_DIV128      7
`define TC_LOG_DIV256      8
`define TC_LOG_DIV1024     10
`define TC_PRESCALE_BITS   10

`endif

// ===== timer8_pkg.sv
`include "timer8_regs.svh"

package timer8_pkg;

    typedef enum logic [2:0] {
        CS_STOP    = `TC_CS_STOP,
        CS_DIV1    = `TC_CS_DIV1,
        CS_DIV8    = `TC_CS_DIV8,
        CS_DIV32   = `TC_CS_DIV32,
        CS_DIV64   = `TC_CS_DIV64,
        CS_DIV128  = `TC_CS_DIV128,
        CS_DIV256  = `TC_CS_DIV256,
        CS_DIV1024 = `TC_CS_DIV1024
    } clock_select_t;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_t;

    typedef struct packed {
        logic [`TC_PRESCALE_BITS-1:0] div_count;
        logic                         ext_prev;
    } prescale_state_t;

    typedef struct packed {
        logic [7:0]              count_value;
        logic [7:0]              compare_a_value;
        logic [7:0]              compare_b_value;
        logic [`TC_IRQ_BITS-1:0] interrupt_mask_reg;
        logic [`TC_IRQ_BITS-1:0] interrupt_flag_reg;
        logic                    match_block;
        count_dir_t              dir;
        logic                    wave_out_a;
        logic                    wave_out_b;
        logic [7:0]              rdata;
        logic                    rvalid;
        logic                    hit;
    } timer_state_t;

endpackage

// ===== timer8_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module timer8_prescaler
    import timer8_pkg::*;
#(
    parameter int PRESCALE_BITS = `TC_PRESCALE_BITS
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire clock_select_t i_clock_select,
    input  wire logic          i_ext_mode,
    input  wire logic          i_ext_rising,
    input  wire logic          i_external_count_input,
    output logic               o_tick
);

    prescale_state_t st;
    prescale_state_t next_st;
    logic            ext_edge;

    // true when the low n bits of the divider are all one
    function automatic logic tap(input logic [`TC_PRESCALE_BITS-1:0] cnt, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < `TC_PRESCALE_BITS; i++) begin
            if (i < n) begin
                r = r & cnt[i];
            end
        end
        return r;
    endfunction

    always_comb begin
        next_st = st;
        next_st.div_count = st.div_count + 1'b1;
        next_st.ext_prev = i_external_count_input;
        // pin edges count even if the pin is an output
        ext_edge = i_ext_rising ? (i_external_count_input & ~st.ext_prev)
                                : (~i_external_count_input & st.ext_prev);
        if (i_ext_mode) begin
            o_tick = ext_edge;
        end else begin
            unique case (i_clock_select)
                CS_STOP:    o_tick = 1'b0;
                CS_DIV1:    o_tick = 1'b1;
                CS_DIV8:    o_tick = tap(st.div_count, `TC_LOG_DIV8);
                CS_DIV32:   o_tick = tap(st.div_count, `TC_LOG_DIV32);
                CS_DIV64:   o_tick = tap(st.div_count, `TC_LOG_DIV64);
                CS_DIV128:  o_tick = tap(st.div_count, `TC_LOG_DIV128);
                CS_DIV256:  o_tick = tap(st.div_count, `TC_LOG_DIV256);
                CS_DIV1024: o_tick = tap(st.div_count, `TC_LOG_DIV1024);
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

`default_nettype wire

// ===== timer8_compare_irq_regs.sv
`timescale 1ns/1ps
`default_nettype none

module timer8_compare_irq_regs
    import timer8_pkg::*;
#(
    parameter int PRESCALE_BITS = `TC_PRESCALE_BITS
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic [7:0]    i_bus_addr,
    input  wire logic          i_bus_io_space,
    input  wire logic          i_bus_wr,
    input  wire logic          i_bus_rd,
    input  wire logic [7:0]    i_bus_wdata,
    output logic [7:0]         o_bus_rdata,
    output logic               o_bus_rvalid,
    output logic               o_bus_hit,
    input  wire clock_select_t i_clock_select,
    input  wire logic          i_ext_mode,
    input  wire logic          i_ext_rising,
    input  wire logic          i_external_count_input,
    input  wire logic          i_pwm_dual_slope,
    input  wire logic          i_global_irq_enable,
    input  wire logic          i_vector_ack_overflow,
    input  wire logic          i_vector_ack_compare_a,
    input  wire logic          i_vector_ack_compare_b,
    output logic               o_irq_overflow,
    output logic               o_irq_compare_a,
    output logic               o_irq_compare_b,
    output logic               o_wave_out_a,
    output logic               o_wave_out_b,
    output logic [7:0]         o_count_value
);

    timer_state_t              st;
    timer_state_t              next_st;
    logic                      tick;
    logic [7:0]                eff_addr;
    logic                      addr_ok;
    logic                      match_a;
    logic                      match_b;
    logic                      wrap;
    logic [`TC_IRQ_BITS-1:0]   flag_set;
    logic [`TC_IRQ_BITS-1:0]   flag_clr;
    logic [7:0]                read_val;
    logic                      read_hit;

    // map a bus address to a data-space address; short i/o adds the offset
    function automatic logic [8:0] map_addr(input logic [7:0] addr, input logic io);
        logic [8:0] r;
        r = {1'b1, addr};
        if (io) begin
            r = {(addr < `TC_IO_LIMIT), 8'(addr + `TC_IO_OFFSET)};
        end
        return r;
    endfunction

    // register lookup shared by read path and write hit detection
    function automatic logic [8:0] reg_read(input logic [7:0] a, input timer_state_t s);
        logic [8:0] r;
        r = {1'b1, `TC_RST_BYTE};
        unique case (a)
            `TC_ADDR_FLAGS: r = {1'b1, 5'h00, s.interrupt_flag_reg};
            `TC_ADDR_MASK:  r = {1'b1, 5'h00, s.interrupt_mask_reg};
            `TC_ADDR_COUNT: r = {1'b1, s.count_value};
            `TC_ADDR_CMP_A: r = {1'b1, s.compare_a_value};
            `TC_ADDR_CMP_B: r = {1'b1, s.compare_b_value};
            default:        r = {1'b0, `TC_RST_BYTE};
        endcase
        return r;
    endfunction

    timer8_prescaler #(
        .PRESCALE_BITS (PRESCALE_BITS)
    ) u_prescaler (
        .i_sys_clk              (i_sys_clk),
        .i_rst_n                (i_rst_n),
        .i_clock_select         (i_clock_select),
        .i_ext_mode             (i_ext_mode),
        .i_ext_rising           (i_ext_rising),
        .i_external_count_input (i_external_count_input),
        .o_tick                 (tick)
    );

    always_comb begin
        next_st = st;

        // address decode; short i/o reaches only 0x20..0x5F
        {addr_ok, eff_addr} = map_addr(i_bus_addr, i_bus_io_space);
        if (eff_addr >= `TC_EXT_IO_BASE && i_bus_io_space) begin
            addr_ok = 1'b0;
        end
        {read_hit, read_val} = reg_read(eff_addr, st);
        read_hit = read_hit & addr_ok;

        // compare units, suppressed on the tick right after a count write
        match_a = tick && !st.match_block
                  && (st.count_value == st.compare_a_value);
        match_b = tick && !st.match_block
                  && (st.count_value == st.compare_b_value);

        // counter advance
        wrap = 1'b0;
        if (tick) begin
            next_st.match_block = 1'b0;
            if (i_pwm_dual_slope && st.dir == DIR_DOWN) begin
                if (st.count_value == `TC_COUNT_BOTTOM) begin
                    next_st.dir = DIR_UP;
                    next_st.count_value = st.count_value + `TC_COUNT_STEP;
                    wrap = 1'b1;
                end else begin
                    next_st.count_value = st.count_value - `TC_COUNT_STEP;
                end
            end else begin
                next_st.dir = DIR_UP;
                if (st.count_value == `TC_COUNT_MAX) begin
                    if (i_pwm_dual_slope) begin
                        next_st.dir = DIR_DOWN;
                        next_st.count_value = st.count_value - `TC_COUNT_STEP;
                    end else begin
                        next_st.count_value = `TC_COUNT_BOTTOM;
                        wrap = 1'b1;
                    end
                end else begin
                    next_st.count_value = st.count_value + `TC_COUNT_STEP;
                end
            end
        end

        // waveform outputs toggle on each match
        if (match_a) begin
            next_st.wave_out_a = ~st.wave_out_a;
        end
        if (match_b) begin
            next_st.wave_out_b = ~st.wave_out_b;
        end

        // flag sources
        flag_set = '0;
        flag_set[`TC_BIT_OVF]   = wrap;
        flag_set[`TC_BIT_CMP_A] = match_a;
        flag_set[`TC_BIT_CMP_B] = match_b;

        flag_clr = '0;
        flag_clr[`TC_BIT_OVF]   = i_vector_ack_overflow;
        flag_clr[`TC_BIT_CMP_A] = i_vector_ack_compare_a;
        flag_clr[`TC_BIT_CMP_B] = i_vector_ack_compare_b;

        // register writes
        if (i_bus_wr && addr_ok) begin
            unique case (eff_addr)
                `TC_ADDR_FLAGS: begin
                    // write one clears, zero leaves; upper bits dropped
                    flag_clr = flag_clr | i_bus_wdata[`TC_IRQ_BITS-1:0];
                end
                `TC_ADDR_MASK: begin
                    next_st.interrupt_mask_reg = i_bus_wdata[`TC_IRQ_BITS-1:0];
                end
                `TC_ADDR_COUNT: begin
                    // load wins over the advance and arms the match block
                    next_st.count_value = i_bus_wdata;
                    next_st.match_block = 1'b1;
                end
                `TC_ADDR_CMP_A: begin
                    next_st.compare_a_value = i_bus_wdata;
                end
                `TC_ADDR_CMP_B: begin
                    next_st.compare_b_value = i_bus_wdata;
                end
                default: begin
                end
            endcase
        end

        // a set in the clearing cycle survives
        next_st.interrupt_flag_reg = (st.interrupt_flag_reg & ~flag_clr) | flag_set;

        // read data is registered and shown one cycle later
        next_st.rvalid = i_bus_rd;
        next_st.hit = (i_bus_rd || i_bus_wr) && read_hit;
        if (i_bus_rd) begin
            next_st.rdata = read_hit ? read_val : `TC_RST_BYTE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_bus_rdata   = st.rdata;
    assign o_bus_rvalid  = st.rvalid;
    assign o_bus_hit     = st.hit;
    assign o_wave_out_a  = st.wave_out_a;
    assign o_wave_out_b  = st.wave_out_b;
    assign o_count_value = st.count_value;

    // interrupt requests gated by enable, global enable and flag
    assign o_irq_overflow  = i_global_irq_enable
                             & st.interrupt_mask_reg[`TC_BIT_OVF]
                             & st.interrupt_flag_reg[`TC_BIT_OVF];
    assign o_irq_compare_a = i_global_irq_enable
                             & st.interrupt_mask_reg[`TC_BIT_CMP_A]
                             & st.interrupt_flag_reg[`TC_BIT_CMP_A];
    assign o_irq_compare_b = i_global_irq_enable
                             & st.interrupt_mask_reg[`TC_BIT_CMP_B]
                             & st.interrupt_flag_reg[`TC_BIT_CMP_B];

endmodule

`default_nettype wire

// ===== timer8_compare_irq_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_irq_regs_chk
    import timer8_pkg::*;
#(
    parameter int PRESCALE_BITS = 10
) (
    input wire logic          i_sys_clk,
    input wire logic          i_rst_n,
    input wire logic [7:0]    i_bus_addr,
    input wire logic          i_bus_io_space,
    input wire logic          i_bus_wr,
    input wire logic          i_bus_rd,
    input wire clock_select_t i_clock_select,
    input wire logic          i_ext_mode,
    input wire logic          i_pwm_dual_slope,
    input wire logic          i_global_irq_enable,
    input wire logic [7:0]    o_bus_rdata,
    input wire logic          o_bus_rvalid,
    input wire logic          o_bus_hit,
    input wire logic          o_irq_overflow,
    input wire logic          o_irq_compare_a,
    input wire logic          o_irq_compare_b,
    input wire logic [7:0]    o_count_value
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rd_pulse;
        1'b1 |=> o_bus_rvalid == $past(i_bus_rd);
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read valid wrong");
    property p_cnt_rd;
        i_bus_rd && !i_bus_io_space && i_bus_addr == 8'hB2
            |=> o_bus_hit && o_bus_rdata == $past(o_count_value);
    endproperty
    a_cnt_rd: assert property (p_cnt_rd) else $error("count read wrong");
    property p_io_flags;
        i_bus_rd && i_bus_io_space && i_bus_addr == 8'h17 |=> o_bus_hit && o_bus_rdata[7:3] == 5'h00;
    endproperty
    a_io_flags: assert property (p_io_flags) else $error("short flag read wrong");
    property p_io_limit;
        (i_bus_rd || i_bus_wr) && i_bus_io_space && i_bus_addr >= 8'h40 |=> !o_bus_hit;
    endproperty
    a_io_limit: assert property (p_io_limit) else $error("short access hit");
    property p_mask_hi;
        i_bus_rd && !i_bus_io_space && i_bus_addr == 8'h70 |=> o_bus_hit && o_bus_rdata[7:3] == 5'h00;
    endproperty
    a_mask_hi: assert property (p_mask_hi) else $error("mask upper bits set");
    property p_stop;
        i_clock_select == CS_STOP && !i_ext_mode && !i_bus_wr |=> $stable(o_count_value);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    property p_div1;
        i_clock_select == CS_DIV1 && !i_ext_mode && !i_pwm_dual_slope && !i_bus_wr
            |=> o_count_value == $past(o_count_value) + 8'h01;
    endproperty
    a_div1: assert property (p_div1) else $error("count not stepping");
    property p_irq_gate;
        !i_global_irq_enable |-> !(o_irq_overflow || o_irq_compare_a || o_irq_compare_b);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
endmodule
bind timer8_compare_irq_regs timer8_compare_irq_regs_chk #(.PRESCALE_BITS(PRESCALE_BITS)) u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus_addr(i_bus_addr),
    .i_bus_io_space(i_bus_io_space), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
    .i_clock_select(i_clock_select), .i_ext_mode(i_ext_mode), .i_pwm_dual_slope(i_pwm_dual_slope),
    .i_global_irq_enable(i_global_irq_enable), .o_bus_rdata(o_bus_rdata),
    .o_bus_rvalid(o_bus_rvalid), .o_bus_hit(o_bus_hit), .o_irq_overflow(o_irq_overflow),
    .o_irq_compare_a(o_irq_compare_a), .o_irq_compare_b(o_irq_compare_b),
    .o_count_value(o_count_value)
);
`default_nettype wire

// ===== timer8_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_cpu_model (
    input  wire logic  i_sys_clk,
    output logic [7:0] o_addr,
    output logic       o_io,
    output logic       o_wr,
    output logic       o_rd,
    output logic [7:0] o_wdata
);
    initial begin
        {o_addr, o_io, o_wr, o_rd, o_wdata} = '0;
    end
    // one byte access, optional idle cycles first; afterwards address and data show inverted values, wr and rd drop, io holds
    task automatic acc(input logic w, input logic io, input logic [7:0] a,
                       input logic [7:0] d, input int idle);
        repeat (idle) @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        {o_addr, o_io, o_wr, o_rd, o_wdata} <= {a, io, w, !w, d};
        @(posedge i_sys_clk);
        {o_addr, o_wr, o_rd, o_wdata} <= {~a, 1'b0, 1'b0, ~d};
    endtask
endmodule
`default_nettype wire

// ===== timer8_compare_irq_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_irq_regs_test
    import timer8_pkg::*;
();
    logic          i_sys_clk, i_rst_n, ext_mode, ext_rise, ext_pin, gie, chk_on;
    clock_select_t cs;
    logic [2:0]    ack, irq, m_msk, m_flg;
    logic [1:0]    wave;
    logic [7:0]    addr, wdata, rdata, cnt, m_cnt, m_ca, m_cb;
    logic          io, wr, rd, rvalid, hit, m_wa, m_wb, m_blk;
    logic [9:0]    m_div, m_rd;
    int            err_count, num_checks, seed;
    logic [7:0]    adr [9] = '{8'h37, 8'h17, 8'h70, 8'h50, 8'hB2, 8'hB3, 8'hB4, 8'h92, 8'h00};
    logic          aio [9] = '{0, 1, 0, 1, 0, 0, 0, 1, 0};
    wire logic [12:0] p_exp = {m_cnt, m_wb, m_wa, m_msk & m_flg & {3{gie}}};

    timer8_compare_irq_regs uut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus_addr(addr), .i_bus_io_space(io),
        .i_bus_wr(wr), .i_bus_rd(rd), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
        .o_bus_rvalid(rvalid), .o_bus_hit(hit), .i_clock_select(cs), .i_ext_mode(ext_mode),
        .i_ext_rising(ext_rise), .i_external_count_input(ext_pin), .i_pwm_dual_slope(1'b0),
        .i_global_irq_enable(gie), .i_vector_ack_overflow(ack[0]),
        .i_vector_ack_compare_a(ack[1]), .i_vector_ack_compare_b(ack[2]),
        .o_irq_overflow(irq[0]), .o_irq_compare_a(irq[1]), .o_irq_compare_b(irq[2]),
        .o_wave_out_a(wave[0]), .o_wave_out_b(wave[1]), .o_count_value(cnt)
    );
    timer8_cpu_model cpu (
        .i_sys_clk(i_sys_clk), .o_addr(addr), .o_io(io), .o_wr(wr), .o_rd(rd), .o_wdata(wdata)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    function automatic int dec(logic s, logic [7:0] a);
        logic [7:0] e;
        e = s ? ((a < 8'h40) ? a + 8'h20 : 8'h00) : a;
        case (e)
            8'h37: return 0;
            8'h70: return 1;
            8'hB2: return 2;
            8'hB3: return 3;
            8'hB4: return 4;
            default: return -1;
        endcase
    endfunction
    function automatic logic [9:0] lmask(clock_select_t c);
        case (c)
            CS_DIV8: return 10'h007;
            CS_DIV32: return 10'h01F;
            CS_DIV64: return 10'h03F;
            CS_DIV128: return 10'h07F;
            CS_DIV256: return 10'h0FF;
            default: return 10'h3FF;
        endcase
    endfunction

    // reference model of counter, compare, flags and registers
    always @(posedge i_sys_clk or negedge i_rst_n) begin : model
        logic tk, ma, mb, ov;
        logic [7:0] rv;
        int r;
        if (!i_rst_n) begin
            {m_cnt, m_ca, m_cb, m_msk, m_flg, m_wa, m_wb, m_blk, m_div, m_rd} <= '0;
        end else begin
            r = dec(io, addr);
            tk = !ext_mode && (cs == CS_DIV1 || (cs >= CS_DIV8 && (m_div & lmask(cs)) == lmask(cs)));
            ma = tk && !m_blk && m_cnt == m_ca;
            mb = tk && !m_blk && m_cnt == m_cb;
            ov = tk && m_cnt == 8'hFF;
            case (r)
                0: rv = {5'h00, m_flg};
                1: rv = {5'h00, m_msk};
                2: rv = m_cnt;
                3: rv = m_ca;
                4: rv = m_cb;
                default: rv = 8'h00;
            endcase
            m_div <= m_div + 10'h001;
            if (tk) {m_cnt, m_blk} <= {m_cnt + 8'h01, 1'b0};
            if (rd) m_rd <= {1'b1, r >= 0, rv};
            if (wr && r == 1) m_msk <= wdata[2:0];
            if (wr && r == 2) {m_cnt, m_blk} <= {wdata, 1'b1};
            if (wr && r == 3) m_ca <= wdata;
            if (wr && r == 4) m_cb <= wdata;
            m_flg <= (m_flg & ~(ack | ((wr && r == 0) ? wdata[2:0] : 3'h0))) | {mb, ma, ov};
            m_wa <= m_wa ^ ma;
            m_wb <= m_wb ^ mb;
        end
    end

    task automatic note(string n, logic ok, logic [12:0] e, logic [12:0] s);
        num_checks++;
        if (!ok) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_port(logic [12:0] e, logic [12:0] s);
        note("ports", s === e, e, s);
    endtask
    task automatic chk_read(logic [9:0] e, logic [9:0] s);
        note("read", s === e, {3'h0, e}, {3'h0, s});
    endtask
    task automatic chk_count(logic [7:0] e, logic [7:0] s);
        note("count", s === e, {5'h00, e}, {5'h00, s});
    endtask
    task automatic rd_chk(logic s, logic [7:0] a);
        cpu.acc(1'b0, s, a, 8'h00, 0);
        #1;
        chk_read(m_rd, {rvalid, hit, rdata});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(negedge i_sys_clk) begin
        if (i_rst_n && chk_on) chk_port(p_exp, {cnt, wave, irq});
    end

    initial begin
        #(8 * 20000);
        err_count++;
        tally_and_finish();
    end

    initial begin : main
        seed = 97819;
        {err_count, num_checks} = '0;
        {i_rst_n, ext_mode, ext_pin, gie, ack} = '0;
        {ext_rise, chk_on} = 2'b11;
        cs = CS_STOP;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        foreach (adr[i]) rd_chk(aio[i], adr[i]);
        repeat (2) begin
            foreach (adr[i]) cpu.acc(1'b1, aio[i], adr[i], 8'($random(seed)), i % 2);
            foreach (adr[i]) rd_chk(aio[i], adr[i]);
        end
        cpu.acc(1'b1, 1'b0, 8'h70, 8'h07, 0);
        cpu.acc(1'b1, 1'b0, 8'hB3, 8'h05, 0);
        cpu.acc(1'b1, 1'b0, 8'hB4, 8'h09, 0);
        cpu.acc(1'b1, 1'b0, 8'hB2, 8'h05, 0);
        for (int k = 0; k < 600; k++) begin
            @(posedge i_sys_clk);
            cs <= CS_DIV1;
            gie <= (k % 300) < 200;
            ack <= (k % 50 == 7) ? 3'($random(seed)) : 3'h0;
        end
        @(posedge i_sys_clk) cs <= CS_STOP;
        rd_chk(1'b1, 8'h17);
        cpu.acc(1'b1, 1'b1, 8'h17, 8'h02, 0);
        rd_chk(1'b0, 8'h37);
        cpu.acc(1'b1, 1'b0, 8'h37, 8'h05, 0);
        rd_chk(1'b1, 8'h17);
        for (int c = 2; c < 8; c++) begin
            @(posedge i_sys_clk) cs <= clock_select_t'(3'(c));
            repeat (2100) @(posedge i_sys_clk);
        end
        @(posedge i_sys_clk) cs <= CS_STOP;
        cpu.acc(1'b1, 1'b0, 8'hB2, 8'h10, 0);
        chk_on <= 1'b0;
        ext_mode <= 1'b1;
        repeat (5) begin
            repeat (3) @(posedge i_sys_clk);
            ext_pin <= 1'b0;
            repeat (3) @(posedge i_sys_clk);
            ext_pin <= 1'b1;
        end
        repeat (4) @(posedge i_sys_clk);
        #1;
        chk_count(8'h15, cnt);
        @(posedge i_sys_clk);
        ext_rise <= 1'b0;
        ext_pin <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        #1;
        chk_count(8'h16, cnt);
        @(posedge i_sys_clk) ext_mode <= 1'b0;
        cpu.acc(1'b1, 1'b0, 8'hB2, 8'h00, 0);
        chk_on <= 1'b1;
        repeat (20) @(posedge i_sys_clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
